// ===== rtl/clk_ctl.sv
// system clock source select, unlock guard and failure monitor
`timescale 1ns/1ps
module clk_ctl (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillator activity, one pulse per sampled oscillator edge
	input wire logic sys_clk_tick,
	input wire logic wdo_tick,
	// crystal option at reset
	input wire logic crystal_disable_option,
	// clock selection out
	output logic [2:0] system_clock_select_field,
	output logic internal_osc_enable,
	output logic crystal_osc_enable,
	output logic watchdog_osc_enable,
	output logic clock_switching,
	// failure events
	output logic primary_fail_event,
	output logic watchdog_fail_event,
	output logic device_halted
);
	//------------------------------------------------------------
	// bus decode
	//------------------------------------------------------------
	logic acc; // access phase
	logic wr_ctl; // write to control register
	logic [7:0] ctl_q; // stored settings
	clk_ctl_pkg::lock_state_t lock_q; // unlock tracker
	logic wdo_failed_q; // watchdog failure sticky
	logic [clk_ctl_pkg::CNT_W-1:0] pcnt_q; // cycles since system edge
	logic [clk_ctl_pkg::CNT_W-1:0] wcnt_q; // system clock edges since watchdog edge
	logic [2:0] want; // source requested for the mux
	logic [2:0] active; // source granted by mux
	logic switching; // mux in handover
	logic xtal_opt_q; // latched option after reset
	logic first_q; // first cycle after reset
	logic pfail; // primary failure detect
	logic wfail; // watchdog failure detect
	logic halt; // dead state

	assign acc = psel && penable && ce;
	assign wr_ctl = acc && pwrite && (paddr == clk_ctl_pkg::OSC_CTL_ADDR);

	function automatic logic sel_valid(input logic [2:0] s);
		sel_valid = (s <= clk_ctl_pkg::SEL_EXT_PIN);
	endfunction

	//------------------------------------------------------------
	// unlock tracker
	//------------------------------------------------------------
	// reads and other addresses pass by untouched
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_q <= clk_ctl_pkg::LOCKED;
		end else if (wr_ctl) begin
			unique case (lock_q)
				clk_ctl_pkg::LOCKED: begin
					if (pwdata[7:0] == clk_ctl_pkg::UNLOCK_FIRST) begin
						lock_q <= clk_ctl_pkg::HALF;
					end
				end
				clk_ctl_pkg::HALF: begin
					if (pwdata[7:0] == clk_ctl_pkg::UNLOCK_SECOND) begin
						lock_q <= clk_ctl_pkg::OPEN;
					end else begin
						lock_q <= clk_ctl_pkg::LOCKED;
					end
				end
				clk_ctl_pkg::OPEN: begin
					lock_q <= clk_ctl_pkg::LOCKED;
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// control register
	//------------------------------------------------------------
	// stored only on the write after a full unlock; recovery forces watchdog
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_q <= clk_ctl_pkg::OSC_CTL_RESET;
		end else if (ce) begin
			if (wr_ctl && lock_q == clk_ctl_pkg::OPEN) begin
				ctl_q <= pwdata[7:0];
			end else if (pfail) begin
				ctl_q[clk_ctl_pkg::SEL_LSB +: clk_ctl_pkg::SEL_W] <=
					clk_ctl_pkg::SEL_WDO;
			end
			if (first_q && !crystal_disable_option) begin
				ctl_q[clk_ctl_pkg::XTL_EN_BIT] <= 1'b1;
			end
		end
	end

	// option sampled on the first cycle after reset release
	always_ff @(posedge clk) begin
		if (rst) begin
			first_q <= 1'b1;
			xtal_opt_q <= 1'b0;
		end else if (ce && first_q) begin
			first_q <= 1'b0;
			xtal_opt_q <= crystal_disable_option;
		end
	end

	//------------------------------------------------------------
	// failure detection
	//------------------------------------------------------------
	// primary: too long without a system clock edge
	assign pfail = ctl_q[clk_ctl_pkg::PFD_EN_BIT] && !wdo_failed_q &&
		ctl_q[clk_ctl_pkg::WDO_EN_BIT] &&
		(ctl_q[2:0] != clk_ctl_pkg::SEL_WDO) &&
		(pcnt_q == clk_ctl_pkg::CNT_W'(clk_ctl_pkg::PFAIL_CYCLES));
	// watchdog: 8004 system clocks without a watchdog edge
	assign wfail = ctl_q[clk_ctl_pkg::WFD_EN_BIT] && !wdo_failed_q &&
		(wcnt_q == clk_ctl_pkg::CNT_W'(clk_ctl_pkg::WFAIL_CYCLES));

	always_ff @(posedge clk) begin
		if (rst) begin
			pcnt_q <= '0;
		end else if (ce) begin
			if (sys_clk_tick || !ctl_q[clk_ctl_pkg::PFD_EN_BIT] || pfail) begin
				pcnt_q <= '0;
			end else begin
				pcnt_q <= pcnt_q + 1'b1;
			end
		end
	end

	// counts only on system clock edges
	always_ff @(posedge clk) begin
		if (rst) begin
			wcnt_q <= '0;
		end else if (ce) begin
			if (wdo_tick || !ctl_q[clk_ctl_pkg::WFD_EN_BIT]) begin
				wcnt_q <= '0;
			end else if (sys_clk_tick && !wfail) begin
				wcnt_q <= wcnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wdo_failed_q <= 1'b0;
		end else if (ce && wfail) begin
			wdo_failed_q <= 1'b1;
		end
	end

	//------------------------------------------------------------
	// source handover
	//------------------------------------------------------------
	assign want = sel_valid(ctl_q[2:0]) ? ctl_q[2:0] : active;
	clk_mux_cell u_mux (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.want(want),
		.active_q(active),
		.switching_q(switching)
	);

	// dead when chosen source is off and primary failure detection is off
	assign halt = ((active == clk_ctl_pkg::SEL_INT_FAST ||
		active == clk_ctl_pkg::SEL_INT_SLOW) && !ctl_q[clk_ctl_pkg::INT_EN_BIT] ||
		active == clk_ctl_pkg::SEL_XTAL && !ctl_q[clk_ctl_pkg::XTL_EN_BIT] ||
		active == clk_ctl_pkg::SEL_WDO && !ctl_q[clk_ctl_pkg::WDO_EN_BIT]) &&
		!ctl_q[clk_ctl_pkg::PFD_EN_BIT];

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			system_clock_select_field <= 3'h0;
			internal_osc_enable <= 1'b1;
			crystal_osc_enable <= 1'b0;
			watchdog_osc_enable <= 1'b1;
			clock_switching <= 1'b0;
			primary_fail_event <= 1'b0;
			watchdog_fail_event <= 1'b0;
			device_halted <= 1'b0;
		end else if (ce) begin
			system_clock_select_field <= active;
			internal_osc_enable <= ctl_q[clk_ctl_pkg::INT_EN_BIT];
			crystal_osc_enable <= ctl_q[clk_ctl_pkg::XTL_EN_BIT];
			watchdog_osc_enable <= ctl_q[clk_ctl_pkg::WDO_EN_BIT];
			clock_switching <= switching;
			primary_fail_event <= pfail;
			watchdog_fail_event <= wfail;
			if (halt) begin
				device_halted <= 1'b1;
			end
		end
	end

	//------------------------------------------------------------
	// apb answer: zero wait states
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel && !penable;
			// unmapped reads and writes alike answer with an error
			pslverr <= psel && !penable && paddr != clk_ctl_pkg::OSC_CTL_ADDR &&
				paddr != clk_ctl_pkg::SRC_STAT_ADDR;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				if (paddr == clk_ctl_pkg::OSC_CTL_ADDR) begin
					prdata <= {24'h0, ctl_q};
				end else if (paddr == clk_ctl_pkg::SRC_STAT_ADDR) begin
					prdata <= {26'h0, xtal_opt_q, wdo_failed_q, switching, active};
				end
			end
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	// first unlock value landing while locked
	sequence s_first_write;
		wr_ctl && pwdata[7:0] == clk_ctl_pkg::UNLOCK_FIRST &&
			lock_q == clk_ctl_pkg::LOCKED;
	endsequence
	// second unlock value landing after the first
	sequence s_second_write;
		wr_ctl && pwdata[7:0] == clk_ctl_pkg::UNLOCK_SECOND &&
			lock_q == clk_ctl_pkg::HALF;
	endsequence
	// the one data write that the open register takes
	sequence s_open_write;
		wr_ctl && lock_q == clk_ctl_pkg::OPEN;
	endsequence
	// unlock steps move the tracker forward
	AST_UNLOCK_FIRST: assert property (@(posedge clk) disable iff (rst)
		s_first_write |=> lock_q == clk_ctl_pkg::HALF) else $error("unlock first step lost");
	AST_UNLOCK_SECOND: assert property (@(posedge clk) disable iff (rst)
		s_second_write |=> lock_q == clk_ctl_pkg::OPEN)
		else $error("unlock second step lost");
	AST_LOCKED_HOLDS: assert property (@(posedge clk) disable iff (rst)
		ce && !pfail && !first_q && lock_q != clk_ctl_pkg::OPEN |=> $stable(ctl_q))
		else $error("locked register changed");
	AST_RELOCK: assert property (@(posedge clk) disable iff (rst)
		s_open_write |=> lock_q == clk_ctl_pkg::LOCKED)
		else $error("register not relocked");
	// open write lands whole
	AST_STORE: assert property (@(posedge clk) disable iff (rst)
		s_open_write |=> ctl_q == $past(pwdata[7:0])) else $error("open write not stored");
	AST_READ_NEUTRAL: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_ctl |=> $stable(lock_q)) else $error("read moved unlock");
	// read answer carries the stored settings one cycle after setup
	AST_READ_DATA: assert property (@(posedge clk) disable iff (rst)
		ce && psel && !penable && !pwrite && paddr == clk_ctl_pkg::OSC_CTL_ADDR |=>
		pready && prdata[7:0] == $past(ctl_q)) else $error("read answer wrong");
	AST_RECOVER: assert property (@(posedge clk) disable iff (rst)
		ce && pfail && !wr_ctl |=> ctl_q[2:0] == clk_ctl_pkg::SEL_WDO)
		else $error("no recovery switch");
	// no event while the watchdog source is primary or switched off
	AST_NO_RECOVER_WDO: assert property (@(posedge clk) disable iff (rst)
		ce && (ctl_q[2:0] == clk_ctl_pkg::SEL_WDO || !ctl_q[clk_ctl_pkg::WDO_EN_BIT]) |=>
		!primary_fail_event) else $error("bad recovery");
	AST_WFAIL_STOPS_P: assert property (@(posedge clk) disable iff (rst)
		ce && wdo_failed_q |=> !primary_fail_event)
		else $error("primary detect after wdo fail");
	// watchdog failure leaves the select field alone
	AST_WFAIL_KEEPS_SRC: assert property (@(posedge clk) disable iff (rst)
		ce && wfail && !pfail && !wr_ctl |=> $stable(ctl_q[2:0]))
		else $error("watchdog failure moved source");
	// internal oscillator enable only moves by software
	AST_INT_NO_AUTO_OFF: assert property (@(posedge clk) disable iff (rst)
		ce && !wr_ctl |=> $stable(ctl_q[clk_ctl_pkg::INT_EN_BIT]))
		else $error("internal enable changed by hardware");
	// granted source only moves after the dead cycle
	AST_NO_RUNT: assert property (@(posedge clk) disable iff (rst)
		ce && !switching |=> $stable(active)) else $error("source changed without gap");
	// dead state holds until reset
	AST_HALT_STICKY: assert property (@(posedge clk) disable iff (rst)
		device_halted |=> device_halted) else $error("halt released without reset");
	AST_EVENT_PULSE: assert property (@(posedge clk) disable iff (rst)
		ce && wfail |=> watchdog_fail_event ##1 !watchdog_fail_event)
		else $error("watchdog event not one pulse");
endmodule

// ===== rtl/clk_ctl_pkg.sv
// constants for the clock select and oscillator failure monitor
//------------------------------------------------------------
//------------------------------------------------------------
package clk_ctl_pkg;
	// register map (byte addresses of the control and status registers)
	localparam logic [11:0] OSC_CTL_ADDR = 12'hF86;
	localparam logic [11:0] SRC_STAT_ADDR = 12'hF88;
	// field positions
	localparam int INT_EN_BIT = 7;
	localparam int XTL_EN_BIT = 6;
	localparam int WDO_EN_BIT = 5;
	localparam int PFD_EN_BIT = 4;
	localparam int WFD_EN_BIT = 3;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam logic [7:0] OSC_CTL_RESET = 8'hA0;
	// unlock values
	localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
	localparam logic [7:0] UNLOCK_SECOND = 8'h18;
	// select codes
	localparam logic [2:0] SEL_INT_FAST = 3'h0;
	localparam logic [2:0] SEL_INT_SLOW = 3'h1;
	localparam logic [2:0] SEL_XTAL = 3'h2;
	localparam logic [2:0] SEL_WDO = 3'h3;
	localparam logic [2:0] SEL_EXT_PIN = 3'h4;
	// timing: 1 kHz threshold at 100 MHz reference clock
	localparam int CLK_HZ = 100000000;
	localparam int PFAIL_THRESH_HZ = 1000;
	localparam int PFAIL_CYCLES = CLK_HZ / PFAIL_THRESH_HZ;
	localparam int WFAIL_CYCLES = 8004;
	localparam int CNT_W = 17;
	// unlock tracker states
	typedef enum logic [1:0] {LOCKED, HALF, OPEN} lock_state_t;
endpackage

// ===== rtl/clk_mux_cell.sv
// glitch-free two-stage handover between selected clock sources
`timescale 1ns/1ps
module clk_mux_cell (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// requested and current source
	input wire logic [2:0] want,
	output logic [2:0] active_q,
	output logic switching_q
);
	//------------------------------------------------------------
	// handover
	//------------------------------------------------------------
	logic gap_q; // one dead cycle between sources
	// old source is parked for a cycle before the new one is granted
	always_ff @(posedge clk) begin
		if (rst) begin
			active_q <= 3'h0;
			gap_q <= 1'b0;
			switching_q <= 1'b0;
		end else if (ce) begin
			if (gap_q) begin
				active_q <= want;
				gap_q <= 1'b0;
				switching_q <= 1'b0;
			end else if (want != active_q) begin
				gap_q <= 1'b1;
				switching_q <= 1'b1;
			end
		end
	end
endmodule

// ===== testbench/osc_model.sv
// oscillator activity model that feeds tick pulses to the clock control block
`timescale 1ns/1ps
module osc_model (
	// clock and run controls
	input wire logic clk,
	input wire logic sys_run,
	input wire logic wdo_run,
	input wire logic wdo_en,
	// tick pulses
	output logic sys_clk_tick,
	output logic wdo_tick
);
	logic [5:0] div_q = 6'h00; // free running divider
	//----------------------------
	// tick generation
	//----------------------------
	// a stopped source gives no ticks, so a dead oscillator looks dead
	always_ff @(posedge clk) begin
		div_q <= div_q + 6'h01;
		sys_clk_tick <= sys_run; // one tick every cycle while running
		wdo_tick <= wdo_run & wdo_en & (div_q == 6'h3F);
	end
endmodule

// ===== testbench/system_clock_select_and_failure_monitor_test.sv
// self-checking bench for the clock select and failure monitor
`timescale 1ns/1ps
module system_clock_select_and_failure_monitor_test;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rv;
	logic pready, pslverr, ev, sys_run = 1'b1, wdo_run = 1'b1, xtl_opt = 1'b1;
	logic sys_clk_tick, wdo_tick, int_en, xtl_en, wdo_en, sw, pev, wev, halted;
	logic [2:0] sel;
	int n_fail = 0, total_checks = 0, n;
	//----------------------------
	// clock, design and oscillators
	//----------------------------
	always #5 clk = ~clk;
	clk_ctl dut_u (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sys_clk_tick(sys_clk_tick),
		.wdo_tick(wdo_tick), .crystal_disable_option(xtl_opt),
		.system_clock_select_field(sel), .internal_osc_enable(int_en),
		.crystal_osc_enable(xtl_en), .watchdog_osc_enable(wdo_en),
		.clock_switching(sw), .primary_fail_event(pev),
		.watchdog_fail_event(wev), .device_halted(halted));
	osc_model osc_u (.clk(clk), .sys_run(sys_run), .wdo_run(wdo_run), .wdo_en(wdo_en),
		.sys_clk_tick(sys_clk_tick), .wdo_tick(wdo_tick));
	//----------------------------
	// shared tasks
	//----------------------------
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// unlock pair then the data write
	task automatic unlock_wr(input logic [7:0] d);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_FIRST);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_SECOND);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, d);
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	//----------------------------
	// scenarios
	//----------------------------
	task automatic t_reset;
		apb(1'b0, clk_ctl_pkg::OSC_CTL_ADDR, 8'h00);
		check(rv, 32'h000000A0);
		check({int_en, xtl_en, wdo_en, sel}, 32'h00000028);
		$display("reset test done");
	endtask
	// locked writes, interleaved cycles, relock, wrong pair, reserved code
	task automatic t_lock;
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, 8'hA1);
		apb(1'b0, clk_ctl_pkg::OSC_CTL_ADDR, 8'h00);
		check(rv, 32'h000000A0);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_FIRST);
		apb(1'b0, clk_ctl_pkg::SRC_STAT_ADDR, 8'h00);
		apb(1'b0, clk_ctl_pkg::OSC_CTL_ADDR, 8'h00);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_SECOND);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, 8'hA1);
		apb(1'b0, clk_ctl_pkg::OSC_CTL_ADDR, 8'h00);
		check(rv, 32'h000000A1);
		#1;
		check(sel, clk_ctl_pkg::SEL_INT_SLOW);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, 8'hA0);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_FIRST);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, 8'h55);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_SECOND);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, 8'hA4);
		apb(1'b0, clk_ctl_pkg::OSC_CTL_ADDR, 8'h00);
		check(rv, 32'h000000A1);
		unlock_wr(8'hA6);
		check(sel, clk_ctl_pkg::SEL_INT_SLOW);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_FIRST);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, clk_ctl_pkg::UNLOCK_SECOND);
		apb(1'b1, clk_ctl_pkg::OSC_CTL_ADDR, 8'hA0);
		repeat (2) @(posedge clk);
		#1;
		check(sw, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		check(sel, clk_ctl_pkg::SEL_INT_FAST);
		apb(1'b0, 12'h100, 8'h00);
		check(ev, 1'b1);
		check(rv, 32'h00000000);
		$display("lock test done");
	endtask
	// primary source stops with detection on
	task automatic t_pfail;
		sys_run <= 1'b0;
		unlock_wr(8'hB0);
		for (n = 4; n < 100200; n++) begin
			@(posedge clk);
			#1;
			if (pev === 1'b1) break;
		end
		check(n > clk_ctl_pkg::PFAIL_CYCLES - 12 && n < clk_ctl_pkg::PFAIL_CYCLES + 12, 1);
		repeat (4) @(posedge clk);
		#1;
		check({sel, wdo_en}, {clk_ctl_pkg::SEL_WDO, 1'b1});
		$display("primary failure test done");
	endtask
	// watchdog oscillator stops with its detection on
	task automatic t_wfail;
		sys_run <= 1'b1;
		unlock_wr(8'hA0);
		wdo_run <= 1'b0;
		unlock_wr(8'hA8);
		n = 0;
		for (int i = 0; i < 20000; i++) begin
			@(posedge clk);
			#1;
			if (wev === 1'b1) break;
			if (sys_clk_tick === 1'b1) n++;
		end
		check(n > clk_ctl_pkg::WFAIL_CYCLES - 8 && n < clk_ctl_pkg::WFAIL_CYCLES + 8 &&
			wev === 1'b1, 1);
		check({sel, pev}, {clk_ctl_pkg::SEL_INT_FAST, 1'b0});
		$display("watchdog failure test done");
	endtask
	task automatic t_halt;
		unlock_wr(8'h20);
		repeat (4) @(posedge clk);
		#1;
		check(halted, 1'b1);
		$display("halt test done");
	endtask
	// mid-run reset with the crystal option low, then crystal and pin sources
	task automatic t_option;
		xtl_opt <= 1'b0;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(halted, 1'b0);
		apb(1'b0, clk_ctl_pkg::OSC_CTL_ADDR, 8'h00);
		check(rv, 32'h000000E0);
		check(xtl_en, 1'b1);
		unlock_wr(8'hE2);
		check(sel, clk_ctl_pkg::SEL_XTAL);
		unlock_wr(8'hA4);
		check(sel, clk_ctl_pkg::SEL_EXT_PIN);
		$display("option test done");
	endtask
	//----------------------------
	// main sequence and watchdog
	//----------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_lock();
		t_pfail();
		t_wfail();
		t_halt();
		t_option();
		finish_test();
	end
	initial begin
		#1500000;
		n_fail++;
		finish_test();
	end
endmodule
